// ==== iop_regs.svh ====
// register offsets, field positions and reset values of the i/o port
`ifndef IOP_REGS_SVH
`define IOP_REGS_SVH
// ****************************************
// register byte addresses
// ****************************************
// register index times four, one aligned word per register
`define IOP_ADDR_W 18
`define IOP_OFF_MODE 18'h3_FF28
`define IOP_OFF_DATA 18'h3_FF58
`define IOP_OFF_PULL 18'h3_FF84
`define IOP_OFF_DIR 18'h3_FF98
`define IOP_IDX_MODE 16'hFFCA
`define IOP_IDX_DATA 16'hFFD6
`define IOP_IDX_PULL 16'hFFE1
`define IOP_IDX_DIR 16'hFFE6
// ****************************************
// reset values
// ****************************************
`define IOP_RST_MODE 8'h04
`define IOP_RST_DATA 8'h00
`define IOP_RST_PULL 8'h00
`define IOP_RST_DIR 8'h00
`define IOP_DIR_READ 8'hFF
// ****************************************
// mode field positions
// ****************************************
`define IOP_M_PWM 0
`define IOP_M_UD 1
`define IOP_M_RST 2
`define IOP_M_IRQ 3
`define IOP_M_NCS 4
`define IOP_M_WDCK 5
`define IOP_M_EVH 6
`define IOP_M_EVL 7
// ****************************************
// timing
// ****************************************
`define IOP_WD_SYS_DIV 8192
`define IOP_WD_WATCH_DIV 32
`define IOP_NC_TAPS 3
`endif

// ==== iop_pkg.sv ====
// types of the i/o port
package iop_pkg;
	typedef logic [7:0] iop_byte_t;
	typedef enum logic [2:0] {
		IOP_IDLE = 3'b001,
		IOP_SETUP = 3'b010,
		IOP_ACCESS = 3'b100
	} iop_apb_st_t;
endpackage

// ==== iop_filter.sv ====
// noise canceller for the capture input
`timescale 1ns/1ns
`include "iop_regs.svh"
module iop_filter (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic din,
	output logic dout
);
	logic [`IOP_NC_TAPS-1:0] sh_q;
	logic dout_q;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sh_q <= '0;
		end else begin
			sh_q <= {sh_q[`IOP_NC_TAPS-2:0], din};
		end
	end
	// when enabled, output changes only when all taps agree; when not enabled it follows din
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dout_q <= 1'b0;
		end else if (!enable) begin
			dout_q <= din;
		end else if (&sh_q) begin
			dout_q <= 1'b1;
		end else if (~|sh_q) begin
			dout_q <= 1'b0;
		end
	end
	assign dout = dout_q;
endmodule // iop_filter

// ==== iop_port.sv ====
// eight-bit i/o port with pin multiplexing, apb registers
`timescale 1ns/1ns
`include "iop_regs.svh"
module iop_port (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [17:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	output logic [7:0] pin_pullup,
	input wire logic pwm_out,
	input wire logic reset_out,
	input wire logic watch_clk_en,
	input wire logic capture_input,
	input wire logic nbr_pin3_in,
	output logic event_count_low_in,
	output logic event_count_high_in,
	output logic count_direction_in,
	output logic ext_interrupt_in,
	output logic nbr_pin3_gpio_in,
	output logic capture_filtered,
	output logic watchdog_clk_en
);
	// ****************************************
	// registers
	// ****************************************
	iop_pkg::iop_byte_t port_data_latch_q;
	iop_pkg::iop_byte_t direction_control_q;
	iop_pkg::iop_byte_t pullup_enable_q;
	iop_pkg::iop_byte_t pin_mode_select_q;
	iop_pkg::iop_byte_t gpio_oe;
	iop_pkg::iop_byte_t gpio_out;
	iop_pkg::iop_byte_t gpio_pu;
	logic [31:0] prdata_q;
	logic slverr_q;
	logic wr_en;
	logic wr_data;
	logic wr_dir;
	logic wr_pull;
	logic wr_mode;
	logic rd_en;
	logic known;
	logic [12:0] sys_div_q;
	logic [4:0] watch_div_q;
	logic wd_en_q;

	function automatic logic hit(input logic [17:0] a, input logic [17:0] off);
		hit = (a[17:2] == off[17:2]);
	endfunction

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign known = hit(paddr, `IOP_OFF_MODE) || hit(paddr, `IOP_OFF_DATA) ||
		hit(paddr, `IOP_OFF_PULL) || hit(paddr, `IOP_OFF_DIR);
	assign pready = 1'b1;
	// byte lane 0 carries every register
	assign wr_data = wr_en && pstrb[0] && hit(paddr, `IOP_OFF_DATA);
	assign wr_dir = wr_en && pstrb[0] && hit(paddr, `IOP_OFF_DIR);
	assign wr_pull = wr_en && pstrb[0] && hit(paddr, `IOP_OFF_PULL);
	assign wr_mode = wr_en && pstrb[0] && hit(paddr, `IOP_OFF_MODE);

	// ****************************************
	// register writes
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			port_data_latch_q <= `IOP_RST_DATA;
		end else if (wr_data) begin
			port_data_latch_q <= pwdata[7:0];
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			direction_control_q <= `IOP_RST_DIR;
		end else if (wr_dir) begin
			direction_control_q <= pwdata[7:0];
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pullup_enable_q <= `IOP_RST_PULL;
		end else if (wr_pull) begin
			pullup_enable_q <= pwdata[7:0];
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_mode_select_q <= `IOP_RST_MODE;
		end else if (wr_mode) begin
			pin_mode_select_q <= pwdata[7:0];
		end
	end

	// ****************************************
	// register reads
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata_q <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata_q <= 32'h0000_0000;
			if (hit(paddr, `IOP_OFF_MODE)) begin
				prdata_q[7:0] <= pin_mode_select_q;
			end else if (hit(paddr, `IOP_OFF_DATA)) begin
				prdata_q[7:0] <= (direction_control_q & port_data_latch_q) |
					(~direction_control_q & pin_in);
			end else if (hit(paddr, `IOP_OFF_PULL)) begin
				prdata_q[7:0] <= pullup_enable_q;
			end else if (hit(paddr, `IOP_OFF_DIR)) begin
				prdata_q[7:0] <= `IOP_DIR_READ;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			slverr_q <= 1'b0;
		end else if (psel && !penable) begin
			slverr_q <= !known;
		end
	end
	assign prdata = rd_en ? prdata_q : 32'h0000_0000;
	assign pslverr = psel && penable && slverr_q;

	// ****************************************
	// pin multiplexing
	// ****************************************
	// general i/o view of every pin
	always_comb begin
		gpio_oe = direction_control_q;
		gpio_out = direction_control_q & port_data_latch_q;
		gpio_pu = ~direction_control_q & pullup_enable_q;
	end
	// alternate functions override the general view pin by pin
	// mode bits 3, 4 and 5 leave the port pins alone
	always_comb begin
		pin_oe = gpio_oe;
		pin_out = gpio_out;
		pin_pullup = gpio_pu;
		if (pin_mode_select_q[`IOP_M_PWM]) begin
			pin_oe[0] = 1'b1;
			pin_out[0] = pwm_out;
			pin_pullup[0] = 1'b0;
		end
		if (pin_mode_select_q[`IOP_M_UD]) begin
			pin_oe[1] = 1'b0;
			pin_out[1] = 1'b0;
			pin_pullup[1] = 1'b0;
		end
		if (pin_mode_select_q[`IOP_M_RST]) begin
			pin_oe[2] = 1'b1;
			pin_out[2] = reset_out;
			pin_pullup[2] = 1'b0;
		end
		if (pin_mode_select_q[`IOP_M_EVH]) begin
			pin_oe[6] = 1'b0;
			pin_out[6] = 1'b0;
			pin_pullup[6] = 1'b0;
		end
		if (pin_mode_select_q[`IOP_M_EVL]) begin
			pin_oe[7] = 1'b0;
			pin_out[7] = 1'b0;
			pin_pullup[7] = 1'b0;
		end
	end
	assign event_count_low_in = pin_mode_select_q[`IOP_M_EVL] & pin_in[7];
	assign event_count_high_in = pin_mode_select_q[`IOP_M_EVH] & pin_in[6];
	assign count_direction_in = pin_mode_select_q[`IOP_M_UD] & pin_in[1];
	// active-low interrupt idles high when not routed
	assign ext_interrupt_in = pin_mode_select_q[`IOP_M_IRQ] ? nbr_pin3_in : 1'b1;
	assign nbr_pin3_gpio_in = pin_mode_select_q[`IOP_M_IRQ] ? 1'b0 : nbr_pin3_in;

	// ****************************************
	// capture noise canceller
	// ****************************************
	iop_filter u_filter (
		.clk(clk),
		.rst_n(rst_n),
		.enable(pin_mode_select_q[`IOP_M_NCS]),
		.din(capture_input),
		.dout(capture_filtered)
	);

	// ****************************************
	// watchdog clock source
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sys_div_q <= 13'h0000;
		end else begin
			sys_div_q <= sys_div_q + 13'h0001;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			watch_div_q <= 5'h00;
		end else if (watch_clk_en) begin
			watch_div_q <= watch_div_q + 5'h01;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wd_en_q <= 1'b0;
		end else if (pin_mode_select_q[`IOP_M_WDCK]) begin
			wd_en_q <= watch_clk_en && (watch_div_q == 5'h1F);
		end else begin
			wd_en_q <= (sys_div_q == 13'h1FFF);
		end
	end
	assign watchdog_clk_en = wd_en_q;
endmodule // iop_port

// ==== iop_port_properties.sv ====
// checker for the i/o port pins and registers
`timescale 1ns/1ns
`include "iop_regs.svh"
module iop_port_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [17:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pin_pullup,
	input wire logic nbr_pin3_in,
	input wire logic ext_interrupt_in,
	input wire logic nbr_pin3_gpio_in,
	input wire logic event_count_low_in,
	input wire logic event_count_high_in,
	input wire logic count_direction_in,
	input wire logic watchdog_clk_en
);
	// ****************************************
	// properties
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic rd, wr;
	assign rd = psel && penable && !pwrite;
	assign wr = psel && penable && pwrite && pstrb[0];
	property p_dir_rd;
		rd && paddr == `IOP_OFF_DIR |-> prdata == 32'h0000_00FF;
	endproperty
	a_dir_rd: assert property (p_dir_rd) else $error("dir read not all ones");
	property p_out_rd;
		rd && paddr == `IOP_OFF_DATA |-> ((prdata[7:0] ^ pin_out) & pin_oe & 8'hFA) == 8'h00;
	endproperty
	a_out_rd: assert property (p_out_rd) else $error("output pin read not latch");
	property p_dir_wr;
		wr && paddr == `IOP_OFF_DIR |=> (pin_oe & 8'h38) == ($past(pwdata[7:0]) & 8'h38);
	endproperty
	a_dir_wr: assert property (p_dir_wr) else $error("direction write not applied");
	property p_dat_wr;
		wr && paddr == `IOP_OFF_DATA |=>
			((pin_out ^ $past(pwdata[7:0])) & pin_oe & 8'h38) == 8'h00;
	endproperty
	a_dat_wr: assert property (p_dat_wr) else $error("latch write not driven");
	property p_pu_wr;
		wr && paddr == `IOP_OFF_PULL |=>
			((pin_pullup ^ $past(pwdata[7:0])) & ~pin_oe & 8'h38) == 8'h00;
	endproperty
	a_pu_wr: assert property (p_pu_wr) else $error("pull-up write not applied");
	property p_irq;
		ext_interrupt_in == nbr_pin3_in || nbr_pin3_gpio_in == nbr_pin3_in;
	endproperty
	a_irq: assert property (p_irq) else $error("neighbour pin routed nowhere");
	property p_evl;
		event_count_low_in |-> !pin_oe[7];
	endproperty
	a_evl: assert property (p_evl) else $error("pin 7 driven while counter input");
	property p_evh;
		event_count_high_in |-> !pin_oe[6];
	endproperty
	a_evh: assert property (p_evh) else $error("pin 6 driven while counter input");
	property p_ud;
		count_direction_in |-> !pin_oe[1];
	endproperty
	a_ud: assert property (p_ud) else $error("pin 1 driven while direction input");
	property p_wd;
		watchdog_clk_en |=> !watchdog_clk_en [*8];
	endproperty
	a_wd: assert property (p_wd) else $error("watchdog pulse too close");
endmodule // iop_port_chk

// ==== iop_board.sv ====
// board model of the eight port pins
`timescale 1ns/1ns
module iop_board (
	input wire logic clk,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pin_pullup,
	input wire logic [7:0] drv_en,
	input wire logic [7:0] drv_val,
	output logic [7:0] pin_in
);
	logic flt_q = 1'b0;
	always @(posedge clk) begin
		flt_q <= ~flt_q;
	end
	// port drives, else board, else pull-up, else a floating level
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pin_oe[i]) begin
				pin_in[i] = pin_out[i];
			end else if (drv_en[i]) begin
				pin_in[i] = drv_val[i];
			end else if (pin_pullup[i]) begin
				pin_in[i] = 1'b1;
			end else begin
				pin_in[i] = flt_q;
			end
		end
	end
endmodule // iop_board

// ==== tb_top.sv ====
// testbench of the i/o port
`timescale 1ns/1ns
`include "iop_regs.svh"
module tb_top;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [17:0] paddr = 18'h0_0000;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic [3:0] pstrb = 4'h1;
	logic [7:0] pin_in, pin_out, pin_oe, pin_pullup, v;
	logic [7:0] drv_en = 8'hFF, drv_val = 8'h3C;
	logic pready, pslverr, err, pwm_out = 0, reset_out = 1, watch_clk_en = 0;
	logic capture_input = 0, nbr_pin3_in = 1, evl, evh, ud, irq, gp3, capf, wdc;
	int miscompares = 0, checked = 0, n;
	always #5 clk = ~clk;
	iop_port u_iop_port (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_pullup(pin_pullup), .pwm_out(pwm_out), .reset_out(reset_out),
		.watch_clk_en(watch_clk_en), .capture_input(capture_input), .nbr_pin3_in(nbr_pin3_in),
		.event_count_low_in(evl), .event_count_high_in(evh), .count_direction_in(ud),
		.ext_interrupt_in(irq), .nbr_pin3_gpio_in(gp3), .capture_filtered(capf),
		.watchdog_clk_en(wdc));
	iop_board u_iop_board (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup(pin_pullup), .drv_en(drv_en), .drv_val(drv_val), .pin_in(pin_in));
	// ****************************************
	// bus tasks and checks
	// ****************************************
	// called at a rising edge; returns one edge after the access, state settled
	task automatic xfer(input logic w, input logic [17:0] a, input logic [7:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		v = prdata[7:0];
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic rdc(input string s, input logic [17:0] a, input logic [7:0] e);
		xfer(0, a, 8'h00);
		chk(s, e, v);
	endtask
	task automatic final_report();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		rdc("mode", `IOP_OFF_MODE, 8'h04);
		chk("slverr", 8'h00, err);
		rdc("pull", `IOP_OFF_PULL, 8'h00);
		rdc("dir", `IOP_OFF_DIR, 8'hFF);
		rdc("data", `IOP_OFF_DATA, 8'h3C);
		chk("oe", 8'h04, pin_oe);
		chk("pu", 8'h00, pin_pullup);
		chk("reset_out", 8'h01, pin_out[2]);
		rdc("hole", 18'h0_0000, 8'h00);
		chk("slverr", 8'h01, err);
	endtask
	task automatic t_gpio();
		xfer(1, `IOP_OFF_MODE, 8'h00);
		xfer(1, `IOP_OFF_DIR, 8'hF0);
		xfer(1, `IOP_OFF_DATA, 8'hA5);
		chk("oe", 8'hF0, pin_oe);
		chk("out", 8'hA0, pin_out & 8'hF0);
		rdc("data", `IOP_OFF_DATA, 8'hAC);
		rdc("dir", `IOP_OFF_DIR, 8'hFF);
		xfer(1, `IOP_OFF_PULL, 8'h0F);
		drv_en <= 8'hF0;
		chk("pu", 8'h0F, pin_pullup & 8'h0F);
		rdc("pulled", `IOP_OFF_DATA, 8'hAF);
		drv_en <= 8'hFF;
	endtask
	task automatic t_alt();
		pwm_out <= 1;
		drv_val <= 8'hFF;
		xfer(1, `IOP_OFF_MODE, 8'hC3);
		repeat (3) @(posedge clk);
		chk("oe", 8'h31, pin_oe);
		chk("pwm", 8'h01, pin_out[0]);
		chk("evl", 8'h01, evl);
		chk("evh", 8'h01, evh);
		chk("ud", 8'h01, ud);
		nbr_pin3_in <= 0;
		xfer(1, `IOP_OFF_MODE, 8'h08);
		chk("irq", 8'h00, {irq, gp3});
		xfer(1, `IOP_OFF_MODE, 8'h00);
		chk("gpio3", 8'h02, {irq, gp3});
	endtask
	task automatic t_cap_wd(input logic [7:0] m, input logic [7:0] e);
		xfer(1, `IOP_OFF_MODE, m);
		capture_input <= 1;
		@(posedge clk);
		capture_input <= 0;
		n = 0;
		repeat (6) @(posedge clk) n += capf;
		chk("cap", e, 8'(n));
	endtask
	initial begin
		#250us;
		miscompares++;
		final_report();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1;
		t_reset();
		t_gpio();
		t_alt();
		t_cap_wd(8'h10, 8'h00);
		t_cap_wd(8'h20, 8'h01);
		watch_clk_en <= 1;
		n = 0;
		repeat (70) @(posedge clk) n += wdc;
		chk("wdog", 8'h02, 8'(n));
		xfer(1, `IOP_OFF_MODE, 8'h00);
		n = 0;
		repeat (8192) @(posedge clk) n += wdc;
		chk("wdsys", 8'h01, 8'(n));
		final_report();
	end
endmodule // tb_top
bind iop_port iop_port_chk u_iop_port_chk (.*);
